// ### hdl/touch_pkg.sv
// constants, register map and types shared by the touch acquisition sequencer
package touch_pkg;

  // ==========================================================================
  // structure
  localparam int NGROUPS = 6;
  localparam int PINS_PER_GROUP = 4;
  localparam int NPINS = 24;
  localparam int CNT_W = 14;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INTEN = 8'h04;
  localparam logic [7:0] ADDR_INTFCLR = 8'h08;
  localparam logic [7:0] ADDR_INTSTS = 8'h0c;
  localparam logic [7:0] ADDR_HYST = 8'h10;
  localparam logic [7:0] ADDR_SMP = 8'h20;
  localparam logic [7:0] ADDR_CHG = 8'h28;
  localparam logic [7:0] ADDR_GRP = 8'h30;
  localparam logic [7:0] ADDR_CNT0 = 8'h34;

  // ==========================================================================
  // field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_POL = 3;
  localparam int CTRL_MAXC = 5;
  localparam int CTRL_PGDIV = 12;
  localparam int CTRL_SSDIV = 15;
  localparam int CTRL_SPREAD_ENABLE = 16;
  localparam int CTRL_SSERR = 17;
  localparam int CTRL_LOW = 24;
  localparam int CTRL_HIGH = 28;
  localparam int INT_EOA = 0;
  localparam int INT_MCE = 1;
  localparam int GRP_DONE = 16;

  // ==========================================================================
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [23:0] HYST_RST = 24'hff_ffff;
  localparam logic [23:0] PINSEL_RST = 24'h00_0000;
  localparam logic [6:0] LFSR_SEED = 7'h01;

  // ==========================================================================
  // timing: spread step and deviation at the 48 MHz reference
  localparam longint SS_REF_HZ = 48_000_000;
  localparam longint SS_STEP_PS = 20_800;
  localparam longint SS_MAX_DEV_PS = 5_333_300;
  localparam int SS_MAX_STEPS = int'(SS_MAX_DEV_PS / SS_STEP_PS);
  localparam int SS_MAX_DEV_CYC = int'(SS_MAX_DEV_PS * SS_REF_HZ / 64'd1_000_000_000_000);

  typedef enum {ST_IDLE, ST_WAIT_SYNC, ST_HIGH, ST_SPREAD, ST_LOW, ST_CHECK} acq_state_e;

  // limit 2^(code+8)-1; the reserved code is taken as the largest limit
  function automatic logic [CNT_W-1:0] max_count(input logic [2:0] code);
    logic [2:0] c;
    c = (code == 3'h7) ? 3'h6 : code;
    max_count = CNT_W'((15'h0100 << c) - 15'h0001);
  endfunction : max_count

endpackage : touch_pkg

// ### hdl/clock_divider.sv
// power-of-two divider producing a one-cycle enable pulse
`timescale 1ns/1ps
module clock_divider import touch_pkg::*; #(
  parameter int SEL_W = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  input wire logic [SEL_W-1:0] sel_i,
  // enable out
  output logic tick_o
);
  localparam int DW = (1 << SEL_W) - 1;
  logic [DW-1:0] cnt_r;
  wire [DW-1:0] last = DW'((1 << sel_i) - 1);

  assign tick_o = run_i & (cnt_r == last);

  // restart on stop so the first pulse of a burst has full length
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (!run_i || tick_o) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule : clock_divider

// ### hdl/group_counter.sv
// per-group charge transfer counter with done latch
`timescale 1ns/1ps
module group_counter import touch_pkg::*; #(
  parameter int CW = CNT_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic clear_i,
  input wire logic step_i,
  input wire logic active_i,
  input wire logic sample_hi_i,
  // state
  output logic [CW-1:0] count_o,
  output logic done_o
);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= '0;
      done_o <= 1'b0;
    end else if (clear_i) begin
      count_o <= '0;
      done_o <= 1'b0;
    end else if (step_i && active_i && !done_o) begin
      count_o <= count_o + 1'b1;
      done_o <= sample_hi_i;
    end
  end
endmodule : group_counter

// ### hdl/touch_sense_controller.sv
// capacitive touch acquisition sequencer with wishbone register slave
//
// Contract
// - six groups, four pins, one counter each
// - each pin selectable as sampling or charging
// - group counter latches when sample reaches threshold
// - pulse all groups until last group done
// - at most one sampling pin per group
// - pulse clock is prescaled bus clock
// - high lasts high+1, low lasts low+1
// - high phase drives charging pin, switch open
// - low phase closes switch to transfer charge
// - spread clock from divided bus clock
// - spread step one clock, deviation bounded
// - timeout stops transfer, sets error flag, interrupts
// - timeout also sets acquisition done flag
// - failing group done flag stays clear
// - hysteresis switchable per pin
// - normal mode starts all groups immediately
// - sync mode waits for sync pin event
// - group done flags, then acquisition done
// - interrupts wake from sleep only
// - start bit cleared by hardware at end
// - max count codes select 255 to 16383
// - sync polarity falling edge or high level
// - prescaler codes divide by 1 to 128
`timescale 1ns/1ps
module touch_sense_controller import touch_pkg::*; #(
  parameter int CW = CNT_W
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // electrode pins and analog switches
  input wire logic [NPINS-1:0] PIN_IN_I,
  output logic [NPINS-1:0] PIN_OUT_O,
  output logic [NPINS-1:0] PIN_OE_O,
  output logic [NGROUPS-1:0] SWITCH_O,
  output logic [NPINS-1:0] HYST_EN_O,
  input wire logic SYNC_I,
  // events and power
  output logic EOA_IRQ_O,
  output logic MCE_IRQ_O,
  input wire logic SLEEP_I,
  output logic WAKE_O
);

  // ==========================================================================
  // reset and input synchronisers
  logic [1:0] rst_sync_r;
  logic [NPINS-1:0] pin_m_r;
  logic [NPINS-1:0] pin_s_r;
  logic sync_m_r;
  logic sync_s_r;
  logic sync_d_r;
  wire rst_n = rst_sync_r[1];

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pin_m_r <= '0;
      pin_s_r <= '0;
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
      sync_d_r <= 1'b0;
    end else begin
      pin_m_r <= PIN_IN_I;
      pin_s_r <= pin_m_r;
      sync_m_r <= SYNC_I;
      sync_s_r <= sync_m_r;
      sync_d_r <= sync_s_r;
    end
  end

  // ==========================================================================
  // registers
  logic [31:0] ctrl_r;
  logic start_r;
  logic [1:0] inten_r;
  logic eoa_r;
  logic mce_r;
  logic [NPINS-1:0] hyst_r;
  logic [NPINS-1:0] smp_r;
  logic [NPINS-1:0] chg_r;
  logic [NGROUPS-1:0] grp_en_r;
  logic ack_r;
  logic [31:0] rdata_nxt;
  acq_state_e state_r;
  acq_state_e state_nxt;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] val,
                                         input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    wmerge = (old & ~m) | (val & m);
  endfunction : wmerge

  // lowest set bit wins, so a group never has two sampling pins
  function automatic logic [3:0] first_one(input logic [3:0] v);
    first_one = v & (~v + 4'h1);
  endfunction : first_one

  wire req = CYC_I & STB_I;
  wire wr = req & WE_I & ack_r;
  wire busy = (state_r != ST_IDLE);
  wire wr_ctrl = wr & (ADR_I == ADDR_CTRL);
  wire wr_inten = wr & (ADR_I == ADDR_INTEN);
  wire wr_clr = wr & (ADR_I == ADDR_INTFCLR);
  wire wr_hyst = wr & (ADR_I == ADDR_HYST) & !busy;
  wire wr_smp = wr & (ADR_I == ADDR_SMP) & !busy;
  wire wr_chg = wr & (ADR_I == ADDR_CHG) & !busy;
  wire wr_grp = wr & (ADR_I == ADDR_GRP) & !busy;
  wire [31:0] ctrl_new = wmerge({ctrl_r[31:2], start_r, ctrl_r[0]}, DAT_I, SEL_I);
  wire [31:0] clr_new = wmerge(32'h0000_0000, DAT_I, SEL_I);
  wire [31:0] hyst_new = wmerge({8'h00, hyst_r}, DAT_I, SEL_I);
  wire [31:0] smp_new = wmerge({8'h00, smp_r}, DAT_I, SEL_I);
  wire [31:0] chg_new = wmerge({8'h00, chg_r}, DAT_I, SEL_I);
  wire enabled = ctrl_r[CTRL_EN];
  wire [3:0] high_len = ctrl_r[CTRL_HIGH +: 4];
  wire [3:0] low_len = ctrl_r[CTRL_LOW +: 4];
  wire [6:0] ss_err = ctrl_r[CTRL_SSERR +: 7];
  wire [CW-1:0] limit = CW'(max_count(ctrl_r[CTRL_MAXC +: 3]));
  wire sync_ok = ctrl_r[CTRL_POL] ? sync_s_r : (sync_d_r & ~sync_s_r);
  wire start_req = start_r & (state_r == ST_IDLE);
  wire xfer = (state_r != ST_IDLE) & (state_r != ST_WAIT_SYNC);
  wire phase_high = (state_r == ST_HIGH) | (state_r == ST_SPREAD);
  wire phase_low = (state_r == ST_LOW);

  // ==========================================================================
  // pulse and spread clocks
  logic pg_tick;
  logic ss_tick;

  // held in spread and check, so every high or low phase starts on a whole period
  clock_divider #(.SEL_W(3)) u_pulse_div (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .run_i((state_r == ST_HIGH) | phase_low),
    .sel_i(ctrl_r[CTRL_PGDIV +: 3]),
    .tick_o(pg_tick)
  );

  clock_divider #(.SEL_W(3)) u_spread_div (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .run_i(state_r == ST_SPREAD),
    .sel_i({2'b00, ctrl_r[CTRL_SSDIV]}),
    .tick_o(ss_tick)
  );

  // ==========================================================================
  // groups
  logic [NGROUPS-1:0] active;
  logic [NGROUPS-1:0] done;
  logic [NGROUPS-1:0] sample_hi;
  logic [NGROUPS-1:0] at_max;
  logic [NGROUPS-1:0] smp_ok;
  logic [CW-1:0] count [NGROUPS];
  logic [3:0] phase_cnt_r;
  wire step = phase_low & pg_tick & (phase_cnt_r == low_len);

  for (genvar g = 0; g < NGROUPS; g++) begin : g_grp
    wire [3:0] smp_sel = first_one(smp_r[4*g +: 4]);
    wire [3:0] chg_sel = chg_r[4*g +: 4] & ~smp_sel;
    wire run = xfer & active[g];
    assign active[g] = grp_en_r[g] & enabled;
    assign sample_hi[g] = |(pin_s_r[4*g +: 4] & smp_sel);
    assign at_max[g] = active[g] & ~done[g] & (count[g] >= limit);
    assign smp_ok[g] = $onehot0(smp_sel);
    // idle and unused pins are held low to keep electrodes discharged
    assign PIN_OUT_O[4*g +: 4] = chg_sel & {4{run & phase_high}};
    assign PIN_OE_O[4*g +: 4] = run ? ~smp_sel & ~(chg_sel & {4{~phase_high}}) : 4'hf;
    assign SWITCH_O[g] = run & phase_low;

    group_counter #(.CW(CW)) u_cnt (
      .clk_i(CLK_I),
      .rst_n_i(rst_n),
      .clear_i(start_req),
      .step_i(step),
      .active_i(active[g]),
      .sample_hi_i(sample_hi[g]),
      .count_o(count[g]),
      .done_o(done[g])
    );
  end

  assign HYST_EN_O = hyst_r;

  // ==========================================================================
  // acquisition sequencer
  logic [6:0] spread_cnt_r;
  logic [6:0] spread_len_r;
  logic [6:0] lfsr_r;
  wire all_done = &(done | ~active);
  wire timeout = |at_max;
  wire in_check = (state_r == ST_CHECK);
  wire acq_end = in_check & (all_done | timeout);
  wire mce_set = in_check & timeout & ~all_done;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start_r && enabled) begin
          state_nxt = ctrl_r[CTRL_MODE] ? ST_WAIT_SYNC : ST_HIGH;
        end
      end
      ST_WAIT_SYNC: begin
        if (sync_ok) begin
          state_nxt = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (pg_tick && phase_cnt_r == high_len) begin
          state_nxt = ctrl_r[CTRL_SPREAD_ENABLE] ? ST_SPREAD : ST_LOW;
        end
      end
      ST_SPREAD: begin
        if (ss_tick && spread_cnt_r == spread_len_r) begin
          state_nxt = ST_LOW;
        end
      end
      ST_LOW: begin
        if (step) begin
          state_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        state_nxt = (all_done || timeout) ? ST_IDLE : ST_HIGH;
      end
    endcase
    if (!enabled) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      phase_cnt_r <= 4'h0;
      spread_cnt_r <= 7'h00;
      spread_len_r <= 7'h00;
      lfsr_r <= LFSR_SEED;
    end else begin
      state_r <= state_nxt;
      lfsr_r <= {lfsr_r[5:0], lfsr_r[6] ^ lfsr_r[5]};
      if (state_nxt != state_r) begin
        phase_cnt_r <= 4'h0;
        spread_cnt_r <= 7'h00;
      end else begin
        if (pg_tick && !phase_low && !phase_high) begin
          phase_cnt_r <= 4'h0;
        end else if (pg_tick && state_r != ST_SPREAD) begin
          phase_cnt_r <= phase_cnt_r + 4'h1;
        end
        if (ss_tick) begin
          spread_cnt_r <= spread_cnt_r + 7'h01;
        end
      end
      // masking keeps the spread within the selected error; not uniform
      if (state_nxt == ST_SPREAD && state_r != ST_SPREAD) begin
        spread_len_r <= lfsr_r & ss_err;
      end
    end
  end

  // ==========================================================================
  // control and flag registers; a hardware set beats a same-cycle clear
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      start_r <= 1'b0;
      inten_r <= 2'b00;
      eoa_r <= 1'b0;
      mce_r <= 1'b0;
      hyst_r <= HYST_RST;
      smp_r <= PINSEL_RST;
      chg_r <= PINSEL_RST;
      grp_en_r <= '0;
    end else begin
      if (wr_ctrl && !busy) begin
        ctrl_r <= {ctrl_new[31:2], 1'b0, ctrl_new[0]};
      end else if (wr_ctrl) begin
        ctrl_r[CTRL_EN] <= ctrl_new[CTRL_EN];
      end
      if (wr_ctrl && ctrl_new[CTRL_START] && ctrl_new[CTRL_EN]) begin
        start_r <= 1'b1;
      end else if (acq_end || !enabled) begin
        start_r <= 1'b0;
      end
      if (wr_inten && SEL_I[0]) begin
        inten_r <= DAT_I[1:0];
      end
      eoa_r <= (eoa_r & ~(wr_clr & clr_new[INT_EOA])) | acq_end;
      mce_r <= (mce_r & ~(wr_clr & clr_new[INT_MCE])) | mce_set;
      if (wr_hyst) begin
        hyst_r <= hyst_new[NPINS-1:0];
      end
      if (wr_smp) begin
        smp_r <= smp_new[NPINS-1:0];
      end
      if (wr_chg) begin
        chg_r <= chg_new[NPINS-1:0];
      end
      if (wr_grp && SEL_I[0]) begin
        grp_en_r <= DAT_I[NGROUPS-1:0];
      end
    end
  end

  assign EOA_IRQ_O = eoa_r & inten_r[INT_EOA];
  assign MCE_IRQ_O = mce_r & inten_r[INT_MCE];
  // no clock runs in stop or standby, so only sleep can be left this way
  assign WAKE_O = SLEEP_I & (EOA_IRQ_O | MCE_IRQ_O);

  // ==========================================================================
  // bus read path
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (ADR_I)
      ADDR_CTRL: rdata_nxt = {ctrl_r[31:2], start_r, ctrl_r[0]};
      ADDR_INTEN: rdata_nxt = {30'h0, inten_r};
      ADDR_INTSTS: rdata_nxt = {30'h0, mce_r, eoa_r};
      ADDR_HYST: rdata_nxt = {8'h00, hyst_r};
      ADDR_SMP: rdata_nxt = {8'h00, smp_r};
      ADDR_CHG: rdata_nxt = {8'h00, chg_r};
      ADDR_GRP: rdata_nxt = {10'h000, done, 10'h000, grp_en_r};
      default: begin
        for (int g = 0; g < NGROUPS; g++) begin
          if (ADR_I == ADDR_CNT0 + 8'(4 * g)) begin
            rdata_nxt = {{(32 - CW){1'b0}}, count[g]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req && !ack_r) begin
        DAT_O <= rdata_nxt;
      end
    end
  end

  assign ACK_O = ack_r;

  // ==========================================================================
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  sequence seq_high_end;
    state_r == ST_HIGH && pg_tick && phase_cnt_r == high_len;
  endsequence

  sequence seq_low_end;
    state_r == ST_LOW && pg_tick && phase_cnt_r == low_len;
  endsequence

  AST_HIGH_LEN: assert property (seq_high_end |=> state_r != ST_HIGH)
    else $error("high phase did not end after high+1 pulse clocks");
  AST_HIGH_HOLD: assert property ((state_r == ST_HIGH && phase_cnt_r != high_len) |=>
    state_r == ST_HIGH || !enabled)
    else $error("high phase ended early");
  AST_LOW_END: assert property (seq_low_end ##1 1'b1 |-> in_check || !enabled)
    else $error("low phase did not reach check");
  AST_SWITCH: assert property (|SWITCH_O |-> phase_low)
    else $error("switch closed outside low phase");
  AST_CHARGE: assert property (xfer && !phase_high |-> PIN_OUT_O == '0)
    else $error("charge pin high outside high phase");
  AST_ONE_SAMPLE: assert property (&smp_ok)
    else $error("more than one sampling pin in a group");
  AST_MCE_EOA: assert property ($rose(mce_r) |-> $rose(eoa_r) || $past(eoa_r))
    else $error("error flag without acquisition done");
  AST_MCE_DONE: assert property (mce_set |=> (done & active) != active)
    else $error("failing group marked done");
  AST_NORMAL: assert property (start_req && enabled && !ctrl_r[CTRL_MODE] |=>
    state_r == ST_HIGH)
    else $error("normal start did not begin transfer");
  AST_SYNC_WAIT: assert property (state_r == ST_WAIT_SYNC && !sync_ok && enabled |=>
    state_r == ST_WAIT_SYNC)
    else $error("transfer began without sync event");
  AST_START_CLR: assert property (acq_end && !wr_ctrl |=> !start_r && state_r == ST_IDLE)
    else $error("start bit not cleared at end");
  AST_CLEAR: assert property (start_req |=> done == '0)
    else $error("done flags not cleared at start");
  AST_SPREAD: assert property (spread_cnt_r <= spread_len_r &&
    int'(spread_len_r) < SS_MAX_STEPS)
    else $error("spread exceeds selected deviation");
  AST_ACK: assert property (ACK_O |=> !ACK_O)
    else $error("ack held longer than one cycle");

endmodule : touch_sense_controller

// ### verification/electrode_model.sv
// electrode and sampling capacitor model for the six pin groups
`timescale 1ns/1ps
module electrode_model import touch_pkg::*; (
  // clock
  input wire logic clk_i,
  // design pins
  input wire logic [NPINS-1:0] pin_out_i,
  input wire logic [NPINS-1:0] pin_oe_i,
  input wire logic [NGROUPS-1:0] switch_i,
  input wire logic [15:0] target_i [NGROUPS],
  // levels seen by the design
  output logic [NPINS-1:0] pin_in_o
);
  int cnt [NGROUPS];
  logic [NGROUPS-1:0] sw_q;
  // ==========================================================================
  // capacitor: one step per transfer, emptied when the whole group is driven low
  always @(posedge clk_i) begin
    sw_q <= switch_i;
    for (int g = 0; g < NGROUPS; g++) begin
      if (&pin_oe_i[4*g+:4] && !(|pin_out_i[4*g+:4])) cnt[g] <= 0;
      else if (switch_i[g] && !sw_q[g]) cnt[g] <= cnt[g] + 1;
    end
  end
  // released pins show the capacitor level, never a stale drive value
  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      pin_in_o[p] = pin_oe_i[p] ? pin_out_i[p] : (cnt[p/4] >= target_i[p/4]);
    end
  end
endmodule : electrode_model

// ### verification/touch_sense_controller_bench.sv
// self-checking bench for the touch acquisition sequencer
`timescale 1ns/1ps
module touch_sense_controller_bench import touch_pkg::*;;
  logic CLK_I = 0, RESET_N_I = 0, CYC_I = 0, STB_I = 0, WE_I = 0, SYNC_I = 0, SLEEP_I = 0;
  logic [7:0] ADR_I = 0;
  logic [3:0] SEL_I = 0;
  logic [31:0] DAT_I = 0, DAT_O, rdat;
  logic ACK_O, EOA_IRQ_O, MCE_IRQ_O, WAKE_O;
  logic [NPINS-1:0] PIN_IN_I, PIN_OUT_O, PIN_OE_O, HYST_EN_O, smp;
  logic [NGROUPS-1:0] SWITCH_O;
  logic [15:0] tgt [NGROUPS];
  int n_fail = 0, samples_checked = 0;

  always #25 CLK_I = ~CLK_I;

  touch_sense_controller dut_u (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CYC_I(CYC_I),
    .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
    .ACK_O(ACK_O), .PIN_IN_I(PIN_IN_I), .PIN_OUT_O(PIN_OUT_O), .PIN_OE_O(PIN_OE_O),
    .SWITCH_O(SWITCH_O), .HYST_EN_O(HYST_EN_O), .SYNC_I(SYNC_I), .EOA_IRQ_O(EOA_IRQ_O),
    .MCE_IRQ_O(MCE_IRQ_O), .SLEEP_I(SLEEP_I), .WAKE_O(WAKE_O));
  electrode_model far_u (.clk_i(CLK_I), .pin_out_i(PIN_OUT_O), .pin_oe_i(PIN_OE_O),
    .switch_i(SWITCH_O), .target_i(tgt), .pin_in_o(PIN_IN_I));

  // ==========================================================================
  // reporting and bus tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic hang(input string what);
    n_fail++;
    $display("unexpected %s expected done seen timeout", what);
    final_report();
  endtask : hang

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= a;
    SEL_I <= 4'hf;
    DAT_I <= d;
    do begin
      @(posedge CLK_I);
      n++;
    end while (ACK_O !== 1'b1 && n < 50);
    if (n >= 50) hang("bus ack");
    rdat = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
  endtask : wb

  function automatic logic [31:0] ctl(int md, int pl, int mc, int dv, int ssd, int sse,
                                      int err, int lo, int hi);
    return 32'(3 | md << CTRL_MODE | pl << CTRL_POL | mc << CTRL_MAXC | dv << CTRL_PGDIV |
      ssd << CTRL_SSDIV | sse << CTRL_SPREAD_ENABLE | err << CTRL_SSERR | lo << CTRL_LOW |
      hi << CTRL_HIGH);
  endfunction : ctl

  // polling keeps the bus busy, so the wait costs no extra cycles
  task automatic finish_acq;
    int n;
    n = 0;
    do begin
      wb(0, ADDR_CTRL, 0);
      n++;
    end while (rdat[CTRL_START] !== 1'b0 && n < 20000);
    if (n >= 20000) hang("start bit clear");
  endtask : finish_acq

  task automatic verify(input logic [5:0] en, input int lim);
    logic [5:0] dn;
    logic mce;
    dn = 0;
    mce = 0;
    for (int g = 0; g < NGROUPS; g++) begin
      dn[g] = en[g] && tgt[g] <= lim;
      mce |= en[g] && tgt[g] > lim;
      wb(0, ADDR_CNT0 + 8'(4*g), 0);
      chk("group count", en[g] ? (tgt[g] < lim ? tgt[g] : lim) : 0, rdat);
    end
    wb(0, ADDR_GRP, 0);
    chk("group done", 32'(dn), 32'(rdat[21:16]));
    wb(0, ADDR_INTSTS, 0);
    chk("status", {30'h0, mce, 1'b1}, rdat);
  endtask : verify

  // ==========================================================================
  // main sequence
  initial begin
    int hi, lo, err, sse, hc, lc, n, cp, lim, gf;
    logic [5:0] en;
    void'($urandom(32'h98a1));
    repeat (3) @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    repeat (4) @(posedge CLK_I);
    chk("pins after reset", 32'h00ff_ffff, {8'h0, PIN_OE_O});
    chk("drive after reset", 0, {2'h0, SWITCH_O, PIN_OUT_O});
    chk("hysteresis after reset", {8'h0, HYST_RST}, {8'h0, HYST_EN_O});
    wb(0, ADDR_CTRL, 0);
    chk("ctrl reset", CTRL_RST, rdat);
    wb(1, 8'hfc, $urandom);
    wb(0, 8'hfc, 0);
    chk("unmapped read", 0, rdat);
    wb(1, ADDR_HYST, $urandom);
    @(posedge CLK_I);
    chk("hysteresis", {8'h0, DAT_I[23:0]}, {8'h0, HYST_EN_O});
    smp = 0;
    for (int g = 0; g < NGROUPS; g++) smp[4*g + $urandom_range(3)] = 1'b1;
    cp = smp[0] ? 1 : 0;
    wb(1, ADDR_SMP, 32'(smp));
    wb(1, ADDR_CHG, 32'(~smp));
    wb(1, ADDR_GRP, 32'h3f);
    for (int d = 0; d < 8; d++) begin
      hi = $urandom_range(3);
      lo = $urandom_range(3);
      err = $urandom_range(7);
      sse = d % 2;
      for (int g = 0; g < NGROUPS; g++) tgt[g] = 3;
      wb(1, ADDR_CTRL, ctl(0, 0, 0, d, d / 4, sse, err, lo, hi));
      n = 0;
      while (PIN_OUT_O[cp] !== 1'b1 && n < 100) begin
        @(posedge CLK_I);
        n++;
      end
      if (n >= 100) hang("first pulse");
      chk("charge pin driven", 1, 32'(PIN_OE_O[cp]));
      hc = 0;
      lc = 0;
      while (PIN_OUT_O[cp] === 1'b1 && hc < 5000) begin
        @(posedge CLK_I);
        hc++;
      end
      while (SWITCH_O[0] === 1'b1 && lc < 5000) begin
        @(posedge CLK_I);
        lc++;
      end
      finish_acq();
      n = (hi + 1) << d;
      if (sse == 0) chk("high phase", n, hc);
      else chk("spread high in range", 1, 32'(hc > n && hc <= n + ((err + 1) << (d / 4))));
      chk("low phase", (lo + 1) << d, lc);
    end
    for (int i = 0; i < 2; i++) begin
      for (int g = 0; g < NGROUPS; g++) tgt[g] = 16'($urandom_range(40, 3));
      en = 6'($urandom_range(63, 1));
      wb(1, ADDR_GRP, 32'(en));
      wb(1, ADDR_INTFCLR, 3);
      wb(1, ADDR_CTRL, ctl(0, 0, 0, 0, 0, 0, 0, 7, 0));
      finish_acq();
      verify(en, 255);
    end
    for (int p = 0; p < 2; p++) begin
      SYNC_I <= !p[0];
      wb(1, ADDR_INTFCLR, 3);
      wb(1, ADDR_CTRL, ctl(1, p, 0, 0, 0, 0, 0, 7, 0));
      repeat (30) @(posedge CLK_I);
      chk("idle before sync", 0, {2'h0, SWITCH_O, PIN_OUT_O});
      SYNC_I <= p[0];
      finish_acq();
      verify(en, 255);
    end
    wb(1, ADDR_GRP, 32'h3f);
    wb(1, ADDR_INTEN, 3);
    SLEEP_I <= 1'b1;
    for (int mc = 0; mc < 2; mc++) begin
      lim = (256 << mc) - 1;
      gf = $urandom_range(5);
      for (int g = 0; g < NGROUPS; g++) tgt[g] = 16'($urandom_range(40, 3));
      tgt[gf] = 16'(lim + 20);
      wb(1, ADDR_INTFCLR, 3);
      wb(1, ADDR_CTRL, ctl(0, 0, mc, 0, 0, 0, 0, 7, 0));
      finish_acq();
      verify(6'h3f, lim);
      chk("irq and wake", 7, {29'h0, WAKE_O, MCE_IRQ_O, EOA_IRQ_O});
      SLEEP_I <= 1'b0;
      @(posedge CLK_I);
      chk("wake outside sleep", 3, {29'h0, WAKE_O, MCE_IRQ_O, EOA_IRQ_O});
      SLEEP_I <= 1'b1;
      wb(1, ADDR_INTFCLR, 3);
      @(posedge CLK_I);
      chk("irq cleared", 0, {29'h0, WAKE_O, MCE_IRQ_O, EOA_IRQ_O});
    end
    final_report();
  end
endmodule : touch_sense_controller_bench
